// ### inc/spp_pkg.sv
// Constants and types shared by both ends of the serial peripheral port.
// Assumes a single 25 MHz system clock on both ends.
package spp_pkg;
	// Character and buffer shape
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	// Timing: serial clock half period, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 40;
	localparam int HALF_PERIOD_NS = 320;
	localparam int HALF_CYC = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Least half period the two-flop input path can follow
	localparam int MIN_HALF_CYC = 8;
	// Frame enable line level that means active / master-active
	localparam logic FEN_ACTIVE = 1'b0;
	// Positions in the synchronised pin vector
	localparam int PIN_SO = 0;
	localparam int PIN_MO = 1;
	localparam int PIN_SCK = 2;
	localparam int PIN_FEN = 3;
	// Reset value of the synchroniser: enable line inactive, rest low
	localparam logic [3:0] PIN_RESET = 4'h8;
	typedef enum logic {
		SPP_IDLE,
		SPP_SHIFT
	} spp_state_t;
endpackage : spp_pkg

// ### inc/spp_link_if.sv
// Four-wire serial link between the port and its remote partner.
// Each end drives output and enable; the wire level is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface spp_link_if;
	logic dev_sclk_o, dev_sclk_oe, far_sclk_o, far_sclk_oe;
	logic dev_mo_o, dev_mo_oe, far_mo_o, far_mo_oe;
	logic dev_so_o, dev_so_oe, far_so_o, far_so_oe;
	logic dev_fen_o, dev_fen_oe, far_fen_o, far_fen_oe;
	logic sclk, mo, so, fen;
	// Wire resolution; undriven enable line floats to inactive
	assign sclk = dev_sclk_oe ? dev_sclk_o : (far_sclk_oe ? far_sclk_o : 1'b0);
	assign mo = dev_mo_oe ? dev_mo_o : (far_mo_oe ? far_mo_o : 1'b0);
	assign so = dev_so_oe ? dev_so_o : (far_so_oe ? far_so_o : 1'b0);
	assign fen = dev_fen_oe ? dev_fen_o : (far_fen_oe ? far_fen_o : ~spp_pkg::FEN_ACTIVE);
	modport dev (
		output dev_sclk_o, dev_sclk_oe, dev_mo_o, dev_mo_oe,
		output dev_so_o, dev_so_oe, dev_fen_o, dev_fen_oe,
		input sclk, mo, so, fen
	);
	modport far (
		output far_sclk_o, far_sclk_oe, far_mo_o, far_mo_oe,
		output far_so_o, far_so_oe, far_fen_o, far_fen_oe,
		input sclk, mo, so, fen
	);
endinterface : spp_link_if
`default_nettype wire

// ### verilog/spp_port.sv
// Serial peripheral port, master or slave, with a transmit FIFO.
// Assumes the link interface on one side and software-facing logic on the
// same clock on the other; link pins are foreign and get synchronised.
// Behaviour
// - All four phase/polarity modes, master and slave
// - Clock idles at polarity level
// - Active flag high only while shifting
// - Clock request follows the active flag
// - Tx flag when buffer empty, rx flag per character
// - Soft reset holds; release gives clean idle
// - Remote master idles clock before slave release
// - Phase-1 slave: no lost, shifted, doubled bits
// - Software resets slave if tx flag twice alone
// - Enable line: output select or conflict input
// - Software loads data only while enable active
// - Inactive enable aborts; software rewrites data
`timescale 1ns/1ns
`default_nettype none

// Transmit FIFO with registered ready and valid
module spp_fifo #(
	parameter int W = spp_pkg::DATA_W,
	parameter int D = spp_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clear,
	input wire logic in_valid,
	output var logic in_ready,
	input wire logic [W-1:0] in_data,
	output var logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	if (D < 2 || (1 << AW) != D) begin : g_chk
		$error("spp_fifo depth must be a power of two");
	end
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	logic wr, rd;
	assign wr = in_valid & in_ready;
	assign rd = out_valid & out_ready;
	assign out_data = mem[rp_q];
	// Occupancy after this cycle
	always_comb begin
		cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
		if (clear) cnt_d = '0;
	end
	// Pointers and flags
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wp_q <= clear ? '0 : wp_q + AW'(wr);
			rp_q <= clear ? '0 : rp_q + AW'(rd);
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (AW+1)'(D); // Full stalls the writer
			out_valid <= cnt_d != '0;
		end
	end
	// Storage
	always_ff @(posedge clock) begin
		if (wr) begin
			mem[wp_q] <= in_data;
		end
	end
endmodule : spp_fifo

module spp_port #(
	parameter int DW = spp_pkg::DATA_W,
	parameter int DEPTH = spp_pkg::FIFO_DEPTH,
	parameter int HALF = spp_pkg::HALF_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	spp_link_if.dev link,
	input wire logic soft_reset_hold,
	input wire logic master_mode,
	input wire logic clock_phase_select,
	input wire logic clock_idle_polarity,
	input wire logic four_pin_mode,
	input wire logic enable_line_mode_select,
	input wire logic tx_valid,
	input wire logic [DW-1:0] tx_data,
	output var logic tx_ready,
	output var logic tx_buffer_empty_flag,
	output var logic [DW-1:0] receive_buffer,
	output var logic rx_char_ready_flag,
	input wire logic rx_ack,
	output var logic transfer_active_flag,
	output var logic clock_request,
	output var logic abort_flag,
	input wire logic abort_ack
);
	localparam int EW = $clog2(2 * DW);
	localparam int BW = $clog2(DW);
	localparam int HW = $clog2(HALF);
	if (DW < 2 || HALF < spp_pkg::MIN_HALF_CYC) begin : g_chk
		$error("spp_port needs DW >= 2 and HALF >= MIN_HALF_CYC");
	end

	logic [3:0] s1_q, s2_q;
	logic sck_prev_q, sclk_q, out_q, busy_q;
	logic sclk_oe_q, mo_oe_q, so_oe_q, fen_o_q, fen_oe_q;
	logic [HW-1:0] hc_q;
	logic [EW-1:0] ec_q;
	logic [BW-1:0] bc_q;
	logic [DW-1:0] sreg_q, rsh_q, head, fifo_data;
	spp_pkg::spp_state_t st_q, st_d;
	logic fifo_valid, fifo_pop;
	logic fen_act, sel, sck, din, tick, lead, trail, lead_s, trail_s, lead_m, trail_m;
	logic conflict, m_start, s_start, active, sample_ev, shift_ev, last_bit, m_done, abort;

	spp_fifo #(.W(DW), .D(DEPTH)) spp_fifo_i (
		.clock(clock),
		.nrst(nrst),
		.clear(soft_reset_hold),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Two-flop synchroniser for every link pin
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_q <= spp_pkg::PIN_RESET;
			s2_q <= spp_pkg::PIN_RESET;
			sck_prev_q <= 1'b0;
		end else begin
			s1_q <= {link.fen, link.sclk, link.mo, link.so};
			s2_q <= s1_q;
			sck_prev_q <= s2_q[spp_pkg::PIN_SCK];
		end
	end

	// Edge and event decode
	assign fen_act = s2_q[spp_pkg::PIN_FEN] == spp_pkg::FEN_ACTIVE;
	assign sck = s2_q[spp_pkg::PIN_SCK];
	assign sel = ~four_pin_mode | fen_act;
	assign din = master_mode ? s2_q[spp_pkg::PIN_SO] : s2_q[spp_pkg::PIN_MO];
	// Only true transitions count, so a non-idle clock at release adds no bit
	assign lead_s = ~master_mode & sel & (sck != sck_prev_q) & (sck != clock_idle_polarity);
	assign trail_s = ~master_mode & sel & (sck != sck_prev_q) & (sck == clock_idle_polarity);
	assign tick = hc_q == HW'(HALF - 1);
	assign lead_m = master_mode & (st_q == spp_pkg::SPP_SHIFT) & tick & ~ec_q[0];
	assign trail_m = master_mode & (st_q == spp_pkg::SPP_SHIFT) & tick & ec_q[0];
	assign lead = lead_m | lead_s;
	assign trail = trail_m | trail_s;
	assign conflict = master_mode & four_pin_mode & ~enable_line_mode_select;
	// Master starts only with the enable input master-active in conflict mode
	assign m_start = master_mode & (st_q == spp_pkg::SPP_IDLE) & fifo_valid & ~soft_reset_hold
		& (~conflict | fen_act);
	assign s_start = ~master_mode & (st_q == spp_pkg::SPP_IDLE) & lead & ~soft_reset_hold;
	assign active = (st_q == spp_pkg::SPP_SHIFT) | s_start;
	// Phase picks which edge samples and which shifts
	assign sample_ev = active & (clock_phase_select ? trail : lead);
	assign shift_ev = active & (clock_phase_select ? lead : trail);
	assign last_bit = sample_ev & (bc_q == BW'(DW - 1));
	assign m_done = trail_m & (ec_q == EW'(2 * DW - 1));
	assign abort = (st_q == spp_pkg::SPP_SHIFT) & four_pin_mode & ~fen_act
		& (conflict | ~master_mode);
	assign fifo_pop = m_start | (s_start & fifo_valid);
	assign head = fifo_valid ? fifo_data : '0; // Slave sends zeros when nothing is queued

	// Transfer state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			spp_pkg::SPP_IDLE: begin
				if (m_start | s_start) st_d = spp_pkg::SPP_SHIFT;
			end
			spp_pkg::SPP_SHIFT: begin
				if (abort | (master_mode ? m_done : last_bit)) st_d = spp_pkg::SPP_IDLE;
			end
		endcase
		if (soft_reset_hold) st_d = spp_pkg::SPP_IDLE;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= spp_pkg::SPP_IDLE;
			busy_q <= 1'b0;
			transfer_active_flag <= 1'b0;
			clock_request <= 1'b0;
		end else begin
			st_q <= st_d;
			busy_q <= st_d == spp_pkg::SPP_SHIFT;
			transfer_active_flag <= st_d == spp_pkg::SPP_SHIFT;
			clock_request <= st_d == spp_pkg::SPP_SHIFT;
		end
	end

	// Master clock generator; the line rests at the polarity level
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hc_q <= '0;
			ec_q <= '0;
			sclk_q <= 1'b0;
		end else begin
			hc_q <= (busy_q & master_mode & ~tick) ? hc_q + 1'b1 : '0;
			if (st_q == spp_pkg::SPP_IDLE) ec_q <= '0;
			else if (tick) ec_q <= ec_q + 1'b1;
			if (st_d == spp_pkg::SPP_IDLE | ~master_mode) sclk_q <= clock_idle_polarity;
			else if (tick) sclk_q <= ~sclk_q;
		end
	end

	// Receive shifter and bit counter
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bc_q <= '0;
			rsh_q <= '0;
		end else begin
			if (~active | abort | last_bit) bc_q <= '0;
			else if (sample_ev) bc_q <= bc_q + 1'b1;
			if (sample_ev) rsh_q <= {rsh_q[DW-2:0], din};
		end
	end

	// Receive buffer and its flag; a new character wins over the acknowledge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			receive_buffer <= '0;
			rx_char_ready_flag <= 1'b0;
		end else begin
			if (last_bit) receive_buffer <= {rsh_q[DW-2:0], din};
			if (soft_reset_hold) rx_char_ready_flag <= 1'b0;
			else if (last_bit) rx_char_ready_flag <= 1'b1;
			else if (rx_ack) rx_char_ready_flag <= 1'b0;
		end
	end

	// Transmit shifter: slave preloads while idle so its first bit is ready
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sreg_q <= '0;
			out_q <= 1'b0;
		end else if (soft_reset_hold) begin
			sreg_q <= '0;
			out_q <= 1'b0;
		end else if (shift_ev) begin
			out_q <= sreg_q[DW-1];
			sreg_q <= {sreg_q[DW-2:0], 1'b0};
		end else if (st_q == spp_pkg::SPP_IDLE && (~master_mode | m_start)) begin
			sreg_q <= clock_phase_select ? head : {head[DW-2:0], 1'b0};
			out_q <= head[DW-1];
		end
	end

	// Software flags; the set wins over the acknowledge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_buffer_empty_flag <= 1'b1;
			abort_flag <= 1'b0;
		end else begin
			tx_buffer_empty_flag <= ~fifo_valid | soft_reset_hold;
			if (soft_reset_hold) abort_flag <= 1'b0;
			else if (abort & conflict) abort_flag <= 1'b1;
			else if (abort_ack) abort_flag <= 1'b0;
		end
	end

	// Pin drivers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclk_oe_q <= 1'b0;
			mo_oe_q <= 1'b0;
			so_oe_q <= 1'b0;
			fen_oe_q <= 1'b0;
			fen_o_q <= ~spp_pkg::FEN_ACTIVE;
		end else begin
			sclk_oe_q <= master_mode & ~soft_reset_hold;
			mo_oe_q <= master_mode & ~soft_reset_hold;
			so_oe_q <= ~master_mode & ~soft_reset_hold & sel;
			fen_oe_q <= master_mode & four_pin_mode & enable_line_mode_select & ~soft_reset_hold;
			fen_o_q <= (st_d == spp_pkg::SPP_SHIFT) ? spp_pkg::FEN_ACTIVE : ~spp_pkg::FEN_ACTIVE;
		end
	end

	assign link.dev_sclk_o = sclk_q;
	assign link.dev_sclk_oe = sclk_oe_q;
	assign link.dev_mo_o = out_q;
	assign link.dev_mo_oe = mo_oe_q;
	assign link.dev_so_o = out_q;
	assign link.dev_so_oe = so_oe_q;
	assign link.dev_fen_o = fen_o_q;
	assign link.dev_fen_oe = fen_oe_q;
endmodule : spp_port
`default_nettype wire

// ### verilog/spp_remote.sv
// Remote partner of the serial port: a plain master or slave engine.
// Assumes the link interface on one side and user logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module spp_remote #(
	parameter int DW = spp_pkg::DATA_W,
	parameter int HALF = spp_pkg::HALF_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	spp_link_if.far link,
	input wire logic master_mode,
	input wire logic clock_phase_select,
	input wire logic clock_idle_polarity,
	input wire logic four_pin_mode,
	input wire logic block_line,
	input wire logic tx_valid,
	input wire logic [DW-1:0] tx_data,
	output var logic tx_ready,
	output var logic rx_valid,
	output var logic [DW-1:0] rx_data,
	output var logic busy
);
	localparam int EW = $clog2(2 * DW);
	localparam int BW = $clog2(DW);
	localparam int HW = $clog2(HALF);
	if (DW < 2 || HALF < spp_pkg::MIN_HALF_CYC) begin : g_chk
		$error("spp_remote needs DW >= 2 and HALF >= MIN_HALF_CYC");
	end

	logic [3:0] s1_q, s2_q;
	logic sck_prev_q, sclk_q, out_q, hold_full_q;
	logic [HW-1:0] hc_q;
	logic [EW-1:0] ec_q;
	logic [BW-1:0] bc_q;
	logic [DW-1:0] hold_q, sreg_q, rsh_q, head;
	spp_pkg::spp_state_t st_q, st_d;
	logic sel, sck, din, tick, lead, trail, m_start, s_start, active, sample_ev, shift_ev, last_bit, done;

	// Two-flop synchroniser
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_q <= spp_pkg::PIN_RESET;
			s2_q <= spp_pkg::PIN_RESET;
			sck_prev_q <= 1'b0;
		end else begin
			s1_q <= {link.fen, link.sclk, link.mo, link.so};
			s2_q <= s1_q;
			sck_prev_q <= s2_q[spp_pkg::PIN_SCK];
		end
	end

	// Event decode
	assign sck = s2_q[spp_pkg::PIN_SCK];
	assign sel = ~four_pin_mode | (s2_q[spp_pkg::PIN_FEN] == spp_pkg::FEN_ACTIVE);
	assign din = master_mode ? s2_q[spp_pkg::PIN_SO] : s2_q[spp_pkg::PIN_MO];
	assign tick = hc_q == HW'(HALF - 1);
	assign lead = master_mode ? (busy & tick & ~ec_q[0])
		: (sel & (sck != sck_prev_q) & (sck != clock_idle_polarity));
	assign trail = master_mode ? (busy & tick & ec_q[0])
		: (sel & (sck != sck_prev_q) & (sck == clock_idle_polarity));
	assign m_start = master_mode & (st_q == spp_pkg::SPP_IDLE) & hold_full_q;
	assign s_start = ~master_mode & (st_q == spp_pkg::SPP_IDLE) & lead;
	assign active = (st_q == spp_pkg::SPP_SHIFT) | s_start;
	assign sample_ev = active & (clock_phase_select ? trail : lead);
	assign shift_ev = active & (clock_phase_select ? lead : trail);
	assign last_bit = sample_ev & (bc_q == BW'(DW - 1));
	assign done = master_mode ? (trail & (ec_q == EW'(2 * DW - 1))) : last_bit;
	assign head = hold_full_q ? hold_q : '0;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			spp_pkg::SPP_IDLE: begin
				if (m_start | s_start) st_d = spp_pkg::SPP_SHIFT;
			end
			spp_pkg::SPP_SHIFT: begin
				if (done | (~master_mode & ~sel)) st_d = spp_pkg::SPP_IDLE;
			end
		endcase
	end

	// State, clock generator and counters
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= spp_pkg::SPP_IDLE;
			busy <= 1'b0;
			hc_q <= '0;
			ec_q <= '0;
			bc_q <= '0;
			sclk_q <= 1'b0;
		end else begin
			st_q <= st_d;
			busy <= st_d == spp_pkg::SPP_SHIFT;
			hc_q <= (busy & master_mode & ~tick) ? hc_q + 1'b1 : '0;
			ec_q <= (st_q == spp_pkg::SPP_IDLE) ? '0 : ec_q + EW'(tick);
			if (~active | last_bit | st_d == spp_pkg::SPP_IDLE) bc_q <= '0;
			else if (sample_ev) bc_q <= bc_q + 1'b1;
			// Clock held at idle level whenever not shifting
			if (st_d == spp_pkg::SPP_IDLE | ~master_mode) sclk_q <= clock_idle_polarity;
			else if (tick) sclk_q <= ~sclk_q;
		end
	end

	// Holding register, shifters and received character
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hold_q <= '0;
			hold_full_q <= 1'b0;
			tx_ready <= 1'b1;
			sreg_q <= '0;
			out_q <= 1'b0;
			rsh_q <= '0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else begin
			if (tx_valid & tx_ready) begin
				hold_q <= tx_data;
				hold_full_q <= 1'b1;
				tx_ready <= 1'b0;
			end else if (m_start | s_start) begin
				hold_full_q <= 1'b0;
				tx_ready <= 1'b1;
			end
			if (shift_ev) begin
				out_q <= sreg_q[DW-1];
				sreg_q <= {sreg_q[DW-2:0], 1'b0};
			end else if (st_q == spp_pkg::SPP_IDLE) begin
				sreg_q <= clock_phase_select ? head : {head[DW-2:0], 1'b0};
				out_q <= head[DW-1];
			end
			if (sample_ev) rsh_q <= {rsh_q[DW-2:0], din};
			if (last_bit) rx_data <= {rsh_q[DW-2:0], din};
			rx_valid <= last_bit;
		end
	end

	assign link.far_sclk_o = sclk_q;
	assign link.far_sclk_oe = master_mode;
	assign link.far_mo_o = out_q;
	assign link.far_mo_oe = master_mode;
	assign link.far_so_o = out_q;
	assign link.far_so_oe = ~master_mode & sel;
	// Slave side holds the enable line master-active; block_line plays a foreign master
	assign link.far_fen_o = (~block_line & (busy | ~master_mode)) ? spp_pkg::FEN_ACTIVE : ~spp_pkg::FEN_ACTIVE;
	assign link.far_fen_oe = block_line | four_pin_mode;
endmodule : spp_remote
`default_nettype wire

// ### verif/spp_link_asserts.sv
// Concurrent checks on the serial link and the port's status outputs.
// Instantiated beside the link interface; sees only plain signals.
`timescale 1ns/1ns
`default_nettype none
module spp_link_asserts #(
	parameter int DW = 8,
	parameter int HALF = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic fen,
	input wire logic dev_sclk_o,
	input wire logic dev_sclk_oe,
	input wire logic dev_fen_o,
	input wire logic dev_fen_oe,
	input wire logic soft_reset_hold,
	input wire logic master_mode,
	input wire logic clock_idle_polarity,
	input wire logic four_pin_mode,
	input wire logic enable_line_mode_select,
	input wire logic tx_ready,
	input wire logic tx_buffer_empty_flag,
	input wire logic rx_char_ready_flag,
	input wire logic transfer_active_flag,
	input wire logic clock_request,
	input wire logic abort_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	localparam int RX_WIN = HALF + 8;
	localparam int MAX_BUSY = 2 * DW * HALF + 8;
	logic act_q;
	logic sclk_q;
	logic [7:0] edges_q;
	int unsigned busy_q;
	logic conflict;
	// Master that watches the enable line for other masters
	assign conflict = master_mode & four_pin_mode & ~enable_line_mode_select;
	// Clock transitions seen since the current frame began
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			act_q <= 1'b0;
			sclk_q <= 1'b0;
			edges_q <= 8'h00;
		end else begin
			act_q <= transfer_active_flag;
			sclk_q <= sclk;
			if (transfer_active_flag && !act_q) begin
				edges_q <= 8'h00;
			end else if (sclk != sclk_q) begin
				edges_q <= edges_q + 8'h01;
			end
		end
	end
	// Length of the current busy spell
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 0;
		end else begin
			busy_q <= transfer_active_flag ? busy_q + 1 : 0;
		end
	end
	request_tracks_a: assert property (clock_request == transfer_active_flag)
		else $error("clock request differs from active flag");
	busy_bounded_a: assert property (busy_q <= MAX_BUSY)
		else $error("active flag held past one character");
	frame_edges_a: assert property ($fell(transfer_active_flag) && master_mode
		|=> (edges_q == 8'(2 * DW)) || abort_flag)
		else $error("frame did not carry two clock edges per bit");
	idle_level_a: assert property (dev_sclk_oe && !transfer_active_flag && !$past(transfer_active_flag)
		&& !soft_reset_hold && !$past(soft_reset_hold) |-> dev_sclk_o == clock_idle_polarity)
		else $error("master clock not at idle level");
	hold_idles_a: assert property (soft_reset_hold |=> !transfer_active_flag)
		else $error("transfer active under soft reset");
	hold_flushes_a: assert property (soft_reset_hold ##1 soft_reset_hold |=> tx_buffer_empty_flag)
		else $error("buffer not flushed by soft reset");
	empty_means_room_a: assert property (tx_buffer_empty_flag && $past(nrst) && !soft_reset_hold |-> tx_ready)
		else $error("empty buffer refuses a write");
	rx_ends_frame_a: assert property ($rose(rx_char_ready_flag) |-> ##[0:RX_WIN] !transfer_active_flag)
		else $error("receive flag not near end of frame");
	enable_out_a: assert property (dev_fen_oe && transfer_active_flag |-> dev_fen_o == spp_pkg::FEN_ACTIVE)
		else $error("enable output inactive during transfer");
	enable_in_a: assert property (conflict && !soft_reset_hold |=> !dev_fen_oe)
		else $error("enable line driven in conflict mode");
	conflict_abort_a: assert property (conflict && transfer_active_flag && fen != spp_pkg::FEN_ACTIVE
		|-> ##[1:6] abort_flag)
		else $error("transfer not aborted by inactive enable");
endmodule : spp_link_asserts
`default_nettype wire

// ### verif/serial_peripheral_port_tb.sv
// Testbench: the port and the remote engine facing each other on the link.
// Assumes the package and interface are compiled first; one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module serial_peripheral_port_tb;
	logic clock, nrst, soft_reset_hold, master_mode, clock_phase_select, clock_idle_polarity;
	logic four_pin_mode, enable_line_mode_select, tx_valid, rx_ack, abort_ack, block_line;
	logic [7:0] tx_data, receive_buffer, r_tx_data, r_rx_data;
	logic tx_ready, tx_buffer_empty_flag, rx_char_ready_flag, transfer_active_flag, clock_request, abort_flag;
	logic r_tx_valid, r_tx_ready, r_rx_valid, r_busy;
	logic [7:0] r_q[$];
	int n_errors, checks;
	spp_link_if link_i ();
	spp_port #(.HALF(8)) spp_port_i (.clock(clock), .nrst(nrst), .link(link_i.dev),
		.soft_reset_hold(soft_reset_hold), .master_mode(master_mode), .clock_phase_select(clock_phase_select),
		.clock_idle_polarity(clock_idle_polarity), .four_pin_mode(four_pin_mode),
		.enable_line_mode_select(enable_line_mode_select), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .tx_buffer_empty_flag(tx_buffer_empty_flag), .receive_buffer(receive_buffer),
		.rx_char_ready_flag(rx_char_ready_flag), .rx_ack(rx_ack), .transfer_active_flag(transfer_active_flag),
		.clock_request(clock_request), .abort_flag(abort_flag), .abort_ack(abort_ack));
	spp_remote #(.HALF(8)) spp_remote_i (.clock(clock), .nrst(nrst), .link(link_i.far),
		.master_mode(!master_mode), .clock_phase_select(clock_phase_select),
		.clock_idle_polarity(clock_idle_polarity), .four_pin_mode(four_pin_mode), .block_line(block_line),
		.tx_valid(r_tx_valid), .tx_data(r_tx_data), .tx_ready(r_tx_ready), .rx_valid(r_rx_valid),
		.rx_data(r_rx_data), .busy(r_busy));
	spp_link_asserts #(.DW(8), .HALF(8)) spp_link_asserts_i (.clock(clock), .nrst(nrst), .sclk(link_i.sclk),
		.fen(link_i.fen), .dev_sclk_o(link_i.dev_sclk_o), .dev_sclk_oe(link_i.dev_sclk_oe),
		.dev_fen_o(link_i.dev_fen_o), .dev_fen_oe(link_i.dev_fen_oe), .soft_reset_hold(soft_reset_hold),
		.master_mode(master_mode), .clock_idle_polarity(clock_idle_polarity), .four_pin_mode(four_pin_mode),
		.enable_line_mode_select(enable_line_mode_select), .tx_ready(tx_ready),
		.tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_char_ready_flag(rx_char_ready_flag),
		.transfer_active_flag(transfer_active_flag), .clock_request(clock_request), .abort_flag(abort_flag));
	// Clock source
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Collect each character the remote end receives
	always @(negedge clock) begin
		if (r_rx_valid === 1'b1) r_q.push_back(r_rx_data);
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// Full reset into a new mode set, port held until the far clock idles
	task automatic setup(input logic m, input logic pl, input logic ph, input logic fp, input logic sm, input logic bl);
		nrst = 1'b0;
		soft_reset_hold = 1'b1;
		master_mode = m;
		clock_idle_polarity = pl;
		clock_phase_select = ph;
		four_pin_mode = fp;
		enable_line_mode_select = sm;
		block_line = bl;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		repeat (4) @(negedge clock);
		soft_reset_hold = 1'b0;
		repeat (2) @(negedge clock);
		r_q.delete();
	endtask : setup
	task automatic dev_write(input logic [7:0] d);
		int n;
		n = 0;
		tx_valid = 1'b1;
		tx_data = d;
		while (tx_ready !== 1'b1 && n < 100) begin @(negedge clock); n++; end
		@(negedge clock);
		tx_valid = 1'b0;
	endtask : dev_write
	task automatic rem_write(input logic [7:0] d);
		int n;
		n = 0;
		r_tx_valid = 1'b1;
		r_tx_data = d;
		while (r_tx_ready !== 1'b1 && n < 100) begin @(negedge clock); n++; end
		@(negedge clock);
		r_tx_valid = 1'b0;
	endtask : rem_write
	task automatic wait_idle();
		int n;
		n = 0;
		while ((r_busy !== 1'b0 || transfer_active_flag !== 1'b0) && n < 1000) begin @(negedge clock); n++; end
		repeat (12) @(negedge clock);
	endtask : wait_idle
	// One character each way in a given role, phase and polarity
	task automatic t_xfer(input logic m, input logic pl, input logic ph);
		logic [7:0] dd, rd;
		int n, seen;
		dd = 8'h96 ^ {6'h00, pl, ph};
		rd = 8'h5a ^ {pl, ph, 6'h00};
		setup(m, pl, ph, 1'b0, 1'b1, 1'b0);
		if (m) begin rem_write(rd); dev_write(dd); end
		else begin dev_write(dd); rem_write(rd); end
		n = 0;
		while (rx_char_ready_flag !== 1'b1 && n < 1000) begin @(negedge clock); n++; end
		chk(rx_char_ready_flag, 8'h01);
		chk(receive_buffer, rd);
		wait_idle();
		chk(8'(r_q.size()), 8'h01);
		if (r_q.size() > 0) chk(r_q[0], dd);
		seen = 0;
		repeat (60) begin @(negedge clock); if (transfer_active_flag !== 1'b0 || clock_request !== 1'b0) seen++; end
		chk(8'(seen), 8'h00);
		chk(link_i.sclk, pl);
		chk(tx_buffer_empty_flag, 8'h01);
		rx_ack = 1'b1;
		@(negedge clock);
		rx_ack = 1'b0;
		chk(rx_char_ready_flag, 8'h00);
		$display("test xfer master=%b pol=%b pha=%b done", m, pl, ph);
	endtask : t_xfer
	// Three words back to back with the enable line driven as output
	task automatic t_burst();
		setup(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		tx_valid = 1'b1;
		for (int i = 0; i < 3; i++) begin tx_data = 8'h10 + 8'(i); @(negedge clock); end
		tx_valid = 1'b0;
		chk(tx_buffer_empty_flag, 8'h00);
		repeat (20) @(negedge clock);
		chk(link_i.fen, spp_pkg::FEN_ACTIVE);
		repeat (3) wait_idle();
		chk(8'(r_q.size()), 8'h03);
		for (int i = 0; i < 3 && i < r_q.size(); i++) chk(r_q[i], 8'h10 + 8'(i));
		$display("test burst done");
	endtask : t_burst
	// Blocked conflict-mode master fills its buffer, then soft reset flushes it
	task automatic t_fill();
		int n, seen;
		setup(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		n = 0;
		tx_valid = 1'b1;
		while (tx_ready === 1'b1 && n < 40) begin tx_data = 8'(n); @(negedge clock); n++; end
		tx_valid = 1'b0;
		chk(8'(n), 8'h10);
		seen = 0;
		repeat (40) begin @(negedge clock); if (transfer_active_flag !== 1'b0) seen++; end
		chk(8'(seen), 8'h00);
		chk(tx_buffer_empty_flag, 8'h00);
		soft_reset_hold = 1'b1;
		repeat (3) @(negedge clock);
		chk(tx_buffer_empty_flag, 8'h01);
		soft_reset_hold = 1'b0;
		repeat (2) @(negedge clock);
		chk(tx_ready, 8'h01);
		chk(transfer_active_flag, 8'h00);
		$display("test fill done");
	endtask : t_fill
	// Conflict-mode master: inactive enable aborts, rewrite resends
	task automatic t_abort();
		setup(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		dev_write(8'hc3);
		repeat (50) @(negedge clock);
		block_line = 1'b1;
		repeat (6) @(negedge clock);
		chk(abort_flag, 8'h01);
		chk(transfer_active_flag, 8'h00);
		abort_ack = 1'b1;
		block_line = 1'b0;
		@(negedge clock);
		abort_ack = 1'b0;
		chk(abort_flag, 8'h00);
		repeat (4) @(negedge clock);
		dev_write(8'hc3);
		repeat (4) @(negedge clock);
		wait_idle();
		chk(8'(r_q.size()), 8'h01);
		if (r_q.size() > 0) chk(r_q[0], 8'hc3);
		$display("test abort done");
	endtask : t_abort
	// Watchdog on the whole run
	initial begin
		#(40 * 40000);
		n_errors++;
		print_verdict();
	end
	// Main sequence
	initial begin
		n_errors = 0;
		checks = 0;
		{nrst, soft_reset_hold, master_mode, clock_phase_select, clock_idle_polarity} = 5'h04;
		{four_pin_mode, enable_line_mode_select, tx_valid, rx_ack, abort_ack, block_line, r_tx_valid} = 7'h00;
		tx_data = 8'h00;
		r_tx_data = 8'h00;
		repeat (5) @(negedge clock);
		for (int k = 0; k < 8; k++) t_xfer(k[2], k[1], k[0]);
		t_burst();
		t_fill();
		t_abort();
		print_verdict();
	end
endmodule : serial_peripheral_port_tb
`default_nettype wire
